// *** logic/clkg_idle_gate.sv ***
// Idle clock control, oscillator flags and per-module clock gating
// Contract
// - Idle stops CPU clock, peripherals keep running
// - Internal run plus sleep with idle enters idle
// - Other run: idle, upper select, sleep; lower ignored
// - Switch to internal stops primary, clears ready
// - Oscillator on when frequency or source nonzero
// - Stable flag set after settle interval
// - Peripheral clocks continue while oscillator settles
// - Stable flag survives sleep when already stable
// - All clear: oscillator off, flag clear
// - Wake: CPU resumes after switch delay
// - Wake leaves idle and select bits unchanged
// - Low-power oscillator runs with watchdog or monitor
// - Enable clear stops function, registers stay accessible
// - Gate bit removes all module clocks
// - Gated module registers ignore writes
// - Four gate registers of per-module bits
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/10ps
module clkg_idle_gate
    import clkg_pkg::*;
#(
    parameter int P_SETTLE = SETTLE_CYC,
    parameter int P_SWITCH = SWITCH_CYC,
    parameter int P_PRI_START = PRI_START_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // Register port
    input wire clkg_bus_t i_bus,
    output logic [DATA_W-1:0] o_rdata,
    // CPU and system events
    input wire logic i_sleep_exec,
    input wire logic i_wake_evt,
    input wire logic i_wdt_en,
    input wire logic i_fscm_en,
    // Clock control
    output logic o_cpu_clk_en,
    output logic o_periph_clk_en,
    output logic o_clk_src_int,
    output logic o_pri_osc_en,
    output logic o_int_osc_en,
    output logic [FREQ_W-1:0] o_int_freq_sel,
    output logic o_lposc_run,
    // Modules
    output logic [NMOD-1:0] o_mod_clk_en,
    output logic [NMOD-1:0] o_mod_func_en,
    // Interrupt
    output logic o_irq
);

    logic [DATA_W-1:0] ctrl_reg;
    logic [DATA_W-1:0] osc_reg;
    logic [DATA_W-1:0] irq_mask_reg;
    logic [DATA_W-1:0] gate_reg [N_GATE_REGS];
    logic [DATA_W-1:0] mod_reg [NMOD];
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_evt;
    clkg_state_t state_reg;
    clkg_state_t state_next;
    logic [CNT_W-1:0] settle_cnt_reg;
    logic [CNT_W-1:0] switch_cnt_reg;
    logic [CNT_W-1:0] pri_cnt_reg;
    logic stable_reg;
    logic pri_rdy_reg;
    logic wake_m_reg;
    logic wake_s_reg;
    logic [DATA_W-1:0] rdata_next;
    logic [NMOD-1:0] gate_vec;
    logic idle_en;
    logic sel_up;
    logic gate_hit;
    logic mod_hit;
    logic mod_gated;
    logic [GATE_IDX_W-1:0] gate_idx;
    logic [MOD_IDX_W-1:0] mod_idx;
    logic [ADDR_W-1:0] gate_off;
    logic [ADDR_W-1:0] mod_off;
    logic settle_done;
    logic switch_done;
    logic pri_done;

    assign idle_en = ctrl_reg[CTRL_IDLE_BIT];
    // Lower select bit is stored but steers nothing
    assign sel_up = ctrl_reg[CTRL_SEL_UP_BIT];

    // Address decode
    assign gate_off = i_bus.addr - ADR_GATE_BASE;
    assign mod_off = i_bus.addr - ADR_MOD_BASE;
    assign gate_hit = (i_bus.addr >= ADR_GATE_BASE) && (gate_off < ADDR_W'(N_GATE_REGS));
    assign mod_hit = (i_bus.addr >= ADR_MOD_BASE) && (mod_off < ADDR_W'(NMOD));
    assign gate_idx = gate_off[GATE_IDX_W-1:0];
    assign mod_idx = mod_off[MOD_IDX_W-1:0];
    assign mod_gated = gate_vec[mod_idx];

    // Wake comes from a pin
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wake_m_reg <= 1'b0;
            wake_s_reg <= 1'b0;
        end else begin
            wake_m_reg <= i_wake_evt;
            wake_s_reg <= wake_m_reg;
        end
    end

    // Control register; wake never touches it
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ctrl_reg <= CTRL_RST;
        end else if (i_bus.wr && i_bus.addr == ADR_CTRL) begin
            ctrl_reg <= i_bus.wdata & CTRL_WMASK;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            osc_reg <= OSC_RST;
        end else if (i_bus.wr && i_bus.addr == ADR_OSC) begin
            osc_reg <= i_bus.wdata & OSC_WMASK;
        end
    end

    // Gate registers
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            for (int g = 0; g < N_GATE_REGS; g++) begin
                gate_reg[g] <= GATE_RST;
            end
        end else if (i_bus.wr && gate_hit) begin
            gate_reg[gate_idx] <= i_bus.wdata;
        end
    end

    // Module control registers, locked while gated
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            for (int m = 0; m < NMOD; m++) begin
                mod_reg[m] <= MOD_RST;
            end
        end else if (i_bus.wr && mod_hit && !mod_gated) begin
            mod_reg[mod_idx] <= i_bus.wdata;
        end
    end

    // Per-module clock and function enables
    genvar gi;
    generate
        for (gi = 0; gi < NMOD; gi++) begin : g_mod
            assign gate_vec[gi] = gate_reg[gi / MOD_PER_REG][gi % MOD_PER_REG];
            assign o_mod_clk_en[gi] = o_periph_clk_en && !gate_vec[gi];
            assign o_mod_func_en[gi] = mod_reg[gi][MOD_EN_BIT] && !gate_vec[gi];
        end
    endgenerate

    // Internal oscillator and multiplexer
    assign o_int_freq_sel = osc_reg[OSC_FREQ_LSB +: FREQ_W];
    assign o_int_osc_en = (o_int_freq_sel != '0) || osc_reg[OSC_LF_BIT];
    assign o_clk_src_int = sel_up;
    assign o_lposc_run = i_wdt_en || i_fscm_en;
    assign settle_done = settle_cnt_reg == CNT_W'(P_SETTLE - 1);

    // Settle timer; sleep does not reset it, so a stable flag survives
    always_ff @(posedge i_clk) begin
        if (i_srst || !o_int_osc_en) begin
            settle_cnt_reg <= '0;
            stable_reg <= 1'b0;
        end else if (!stable_reg) begin
            if (settle_done) begin
                stable_reg <= 1'b1;
            end else begin
                settle_cnt_reg <= settle_cnt_reg + CNT_W'(1);
            end
        end
    end

    // Primary oscillator stops once the internal mux is chosen
    assign o_pri_osc_en = !sel_up && state_reg != ST_SLEEP;
    assign pri_done = pri_cnt_reg == CNT_W'(P_PRI_START - 1);

    always_ff @(posedge i_clk) begin
        if (i_srst || !o_pri_osc_en) begin
            pri_cnt_reg <= '0;
            pri_rdy_reg <= 1'b0;
        end else if (!pri_rdy_reg) begin
            if (pri_done) begin
                pri_rdy_reg <= 1'b1;
            end else begin
                pri_cnt_reg <= pri_cnt_reg + CNT_W'(1);
            end
        end
    end

    // Power state machine
    assign switch_done = switch_cnt_reg == CNT_W'(P_SWITCH - 1);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN_PRI: begin
                if (i_sleep_exec) begin
                    state_next = idle_en ? ST_IDLE : ST_SLEEP;
                end else if (sel_up) begin
                    state_next = ST_RUN_INT;
                end
            end
            ST_RUN_INT: begin
                if (i_sleep_exec) begin
                    state_next = idle_en ? ST_IDLE : ST_SLEEP;
                end else if (!sel_up) begin
                    state_next = ST_RUN_PRI;
                end
            end
            ST_IDLE, ST_SLEEP: begin
                if (wake_s_reg) begin
                    state_next = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (switch_done) begin
                    state_next = sel_up ? ST_RUN_INT : ST_RUN_PRI;
                end
            end
            default: begin
                state_next = ST_RUN_PRI;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_reg <= ST_RUN_PRI;
        end else begin
            state_reg <= state_next;
        end
    end

    // Switch delay counter
    always_ff @(posedge i_clk) begin
        if (i_srst || state_reg != ST_WAKE) begin
            switch_cnt_reg <= '0;
        end else if (!switch_done) begin
            switch_cnt_reg <= switch_cnt_reg + CNT_W'(1);
        end
    end

    // Peripherals stay clocked while settling, in idle and during wake
    assign o_cpu_clk_en = state_reg == ST_RUN_PRI || state_reg == ST_RUN_INT;
    assign o_periph_clk_en = state_reg != ST_SLEEP;

    // Interrupt status; set wins over read clear
    assign irq_evt[IRQ_WAKE] = (state_reg == ST_IDLE || state_reg == ST_SLEEP) && wake_s_reg;
    assign irq_evt[IRQ_STABLE] = o_int_osc_en && !stable_reg && settle_done;
    assign irq_evt[IRQ_RESUME] = state_reg == ST_WAKE && switch_done;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            irq_stat_reg <= IRQ_RST;
        end else if (i_bus.rd && i_bus.addr == ADR_IRQ_STAT) begin
            irq_stat_reg <= irq_evt;
        end else begin
            irq_stat_reg <= irq_stat_reg | irq_evt;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            irq_mask_reg <= '0;
        end else if (i_bus.wr && i_bus.addr == ADR_IRQ_MASK) begin
            irq_mask_reg <= i_bus.wdata;
        end
    end

    assign o_irq = |(irq_stat_reg & irq_mask_reg[IRQ_W-1:0]);

    // Read mux
    always_comb begin
        rdata_next = '0;
        if (i_bus.addr == ADR_CTRL) begin
            rdata_next = ctrl_reg;
        end else if (i_bus.addr == ADR_OSC) begin
            rdata_next = osc_reg;
            rdata_next[OSC_STABLE_BIT] = stable_reg;
            rdata_next[OSC_PRI_RDY_BIT] = pri_rdy_reg;
        end else if (gate_hit) begin
            rdata_next = gate_reg[gate_idx];
        end else if (i_bus.addr == ADR_IRQ_STAT) begin
            rdata_next = DATA_W'(irq_stat_reg);
        end else if (i_bus.addr == ADR_IRQ_MASK) begin
            rdata_next = irq_mask_reg;
        end else if (mod_hit && !mod_gated) begin
            rdata_next = mod_reg[mod_idx];
        end
    end

    // Data only in the cycle after the read
    always_ff @(posedge i_clk) begin
        if (i_srst || !i_bus.rd) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= rdata_next;
        end
    end

    a_idle_clocks: assert property (@(posedge i_clk) disable iff (i_srst)
        state_reg == ST_IDLE |-> !o_cpu_clk_en && o_periph_clk_en)
        else $error("idle clocks wrong");

    a_int_idle_entry: assert property (@(posedge i_clk) disable iff (i_srst)
        state_reg == ST_RUN_INT && i_sleep_exec && idle_en |=> state_reg == ST_IDLE)
        else $error("idle not entered");

    a_pri_idle_entry: assert property (@(posedge i_clk) disable iff (i_srst)
        state_reg == ST_RUN_PRI && i_sleep_exec && idle_en |=> state_reg == ST_IDLE && !o_cpu_clk_en)
        else $error("idle from primary run failed");

    a_pri_shutdown: assert property (@(posedge i_clk) disable iff (i_srst)
        sel_up |-> !o_pri_osc_en ##1 !pri_rdy_reg)
        else $error("primary not stopped");

    a_settle_time: assert property (@(posedge i_clk) disable iff (i_srst)
        $rose(stable_reg) |-> $past(settle_cnt_reg) == CNT_W'(P_SETTLE - 1) && $past(o_int_osc_en))
        else $error("stable flag early");

    a_settle_periph: assert property (@(posedge i_clk) disable iff (i_srst)
        o_int_osc_en && !stable_reg && state_reg != ST_SLEEP |-> o_periph_clk_en)
        else $error("peripheral clock lost while settling");

    a_stable_kept: assert property (@(posedge i_clk) disable iff (i_srst)
        stable_reg && i_sleep_exec && !(i_bus.wr && i_bus.addr == ADR_OSC) |=> stable_reg)
        else $error("stable flag lost at sleep");

    a_osc_off_flag: assert property (@(posedge i_clk) disable iff (i_srst)
        !o_int_osc_en && !$past(o_int_osc_en) |-> !stable_reg)
        else $error("stable flag without oscillator");

    a_wake_delay: assert property (@(posedge i_clk) disable iff (i_srst)
        $fell(state_reg == ST_WAKE) |-> $past(switch_cnt_reg) == CNT_W'(P_SWITCH - 1) && o_cpu_clk_en)
        else $error("resume delay wrong");

    a_wake_ctrl: assert property (@(posedge i_clk) disable iff (i_srst)
        irq_evt[IRQ_WAKE] && !i_bus.wr |=> $stable(ctrl_reg))
        else $error("wake changed control");

    a_lposc_run: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_wdt_en || i_fscm_en) |-> o_lposc_run)
        else $error("low-power oscillator stopped");

    a_gate_write: assert property (@(posedge i_clk) disable iff (i_srst)
        i_bus.wr && mod_hit && mod_gated |=> mod_reg[$past(mod_idx)] == $past(mod_reg[mod_idx]))
        else $error("gated module written");

    a_gate_read: assert property (@(posedge i_clk) disable iff (i_srst)
        i_bus.rd && mod_hit && mod_gated |=> o_rdata == '0)
        else $error("gated module read data");

    a_open_write: assert property (@(posedge i_clk) disable iff (i_srst)
        i_bus.wr && mod_hit && !mod_gated |=> mod_reg[$past(mod_idx)] == $past(i_bus.wdata))
        else $error("enabled-off module not writable");

    a_gate_clocks: assert property (@(posedge i_clk) disable iff (i_srst)
        (o_mod_clk_en & gate_vec) == '0 && (o_mod_func_en & gate_vec) == '0)
        else $error("gated module still clocked");

endmodule

// *** logic/clkg_pkg.sv ***
// Constants, types and register map of the idle clock and module gate block
package clkg_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int N_GATE_REGS = 4;
    localparam int MOD_PER_REG = 8;
    localparam int NMOD = N_GATE_REGS * MOD_PER_REG;
    localparam int MOD_IDX_W = $clog2(NMOD);
    localparam int GATE_IDX_W = $clog2(N_GATE_REGS);
    localparam int CNT_W = 12;

    // Register map
    localparam logic [ADDR_W-1:0] ADR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADR_OSC = 8'h01;
    localparam logic [ADDR_W-1:0] ADR_GATE_BASE = 8'h04;
    localparam logic [ADDR_W-1:0] ADR_IRQ_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] ADR_IRQ_MASK = 8'h09;
    localparam logic [ADDR_W-1:0] ADR_MOD_BASE = 8'h40;

    // Control register fields
    localparam int CTRL_IDLE_BIT = 7;
    localparam int CTRL_SEL_UP_BIT = 1;
    localparam int CTRL_SEL_LO_BIT = 0;
    localparam logic [DATA_W-1:0] CTRL_WMASK = 8'h83;
    localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;

    // Oscillator register fields
    localparam int OSC_FREQ_LSB = 4;
    localparam int FREQ_W = 3;
    localparam int OSC_PRI_RDY_BIT = 3;
    localparam int OSC_STABLE_BIT = 2;
    localparam int OSC_LF_BIT = 0;
    localparam logic [DATA_W-1:0] OSC_WMASK = 8'h71;
    localparam logic [DATA_W-1:0] OSC_RST = 8'h00;

    localparam logic [DATA_W-1:0] GATE_RST = 8'h00;
    localparam logic [DATA_W-1:0] MOD_RST = 8'h00;
    localparam int MOD_EN_BIT = 0;

    // Interrupt status bits
    localparam int IRQ_W = 3;
    localparam int IRQ_WAKE = 0;
    localparam int IRQ_STABLE = 1;
    localparam int IRQ_RESUME = 2;
    localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

    // Timing
    localparam int CLK_MHZ = 200;
    localparam int SETTLE_NS = 1000;
    localparam int SWITCH_NS = 200;
    localparam int PRI_START_NS = 5000;
    localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int SWITCH_CYC = (SWITCH_NS * CLK_MHZ + 999) / 1000;
    localparam int PRI_START_CYC = (PRI_START_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic [4:0] {
        ST_RUN_PRI = 5'b00001,
        ST_RUN_INT = 5'b00010,
        ST_IDLE = 5'b00100,
        ST_WAKE = 5'b01000,
        ST_SLEEP = 5'b10000
    } clkg_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } clkg_bus_t;
endpackage

// *** testbench/clkg_far_model.sv ***
// Far-side model: CPU issuing sleep and one peripheral counting its clocks
`timescale 1ns/10ps
module clkg_far_model
    import clkg_pkg::*;
#(
    parameter int P_MOD = 0
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // From the block
    input wire logic i_cpu_clk_en,
    input wire logic [NMOD-1:0] i_mod_clk_en,
    // From the bench
    input wire logic i_sleep_req,
    // To the block and the bench
    output logic o_sleep_exec,
    output logic [15:0] o_cpu_ticks,
    output logic [15:0] o_mod_ticks
);
    // Sleep is an instruction, so only a running CPU can issue it
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_sleep_exec <= 1'b0;
        end else begin
            o_sleep_exec <= i_sleep_req & i_cpu_clk_en;
        end
    end

    // CPU work done; must freeze while idle
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_cpu_ticks <= 16'h0000;
        end else if (i_cpu_clk_en) begin
            o_cpu_ticks <= o_cpu_ticks + 16'h0001;
        end
    end

    // Peripheral work done; freezes when gated or in sleep
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_mod_ticks <= 16'h0000;
        end else if (i_mod_clk_en[P_MOD]) begin
            o_mod_ticks <= o_mod_ticks + 16'h0001;
        end
    end
endmodule

// *** testbench/tb_top.sv ***
// Self-checking bench for the idle clock and module gate block
`timescale 1ns/10ps
module tb_top import clkg_pkg::*;;
    localparam int P_SETTLE = 4;
    localparam int P_SWITCH = 3;
    localparam int P_PRI = 5;
    localparam int P_MOD = 17;
    logic i_clk;
    logic i_srst;
    clkg_bus_t i_bus;
    logic [DATA_W-1:0] o_rdata;
    logic sleep_req;
    logic sleep_exec;
    logic i_wake_evt;
    logic i_wdt_en;
    logic i_fscm_en;
    logic o_cpu_clk_en;
    logic o_periph_clk_en;
    logic o_clk_src_int;
    logic o_pri_osc_en;
    logic o_int_osc_en;
    logic [FREQ_W-1:0] o_int_freq_sel;
    logic o_lposc_run;
    logic [NMOD-1:0] o_mod_clk_en;
    logic [NMOD-1:0] o_mod_func_en;
    logic o_irq;
    logic [15:0] cpu_ticks;
    logic [15:0] mod_ticks;
    int n_errors;
    int checks;

    clkg_idle_gate #(.P_SETTLE(P_SETTLE), .P_SWITCH(P_SWITCH), .P_PRI_START(P_PRI)) i_clkg_idle_gate (
        .i_clk(i_clk), .i_srst(i_srst), .i_bus(i_bus), .o_rdata(o_rdata),
        .i_sleep_exec(sleep_exec), .i_wake_evt(i_wake_evt), .i_wdt_en(i_wdt_en), .i_fscm_en(i_fscm_en),
        .o_cpu_clk_en(o_cpu_clk_en), .o_periph_clk_en(o_periph_clk_en), .o_clk_src_int(o_clk_src_int),
        .o_pri_osc_en(o_pri_osc_en), .o_int_osc_en(o_int_osc_en), .o_int_freq_sel(o_int_freq_sel),
        .o_lposc_run(o_lposc_run), .o_mod_clk_en(o_mod_clk_en), .o_mod_func_en(o_mod_func_en), .o_irq(o_irq));

    clkg_far_model #(.P_MOD(P_MOD)) i_clkg_far_model (
        .i_clk(i_clk), .i_srst(i_srst), .i_cpu_clk_en(o_cpu_clk_en), .i_mod_clk_en(o_mod_clk_en),
        .i_sleep_req(sleep_req), .o_sleep_exec(sleep_exec), .o_cpu_ticks(cpu_ticks), .o_mod_ticks(mod_ticks));

    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge i_clk);
        i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk);
        i_bus <= '0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge i_clk);
        i_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk);
        i_bus <= '0;
        #1;
        chk(what, e, o_rdata);
    endtask

    task automatic t_reset;
        @(posedge i_clk);
        #1;
        chk("cpu clk", 1'b1, o_cpu_clk_en);
        chk("periph clk", 1'b1, o_periph_clk_en);
        chk("pri osc", 1'b1, o_pri_osc_en);
        chk("int osc", 1'b0, o_int_osc_en);
        chk("mod clk", 32'hffffffff, o_mod_clk_en);
        chk("mod func", 32'h0, o_mod_func_en);
        repeat (P_PRI + 2) @(posedge i_clk);
        rd_chk("osc rst", ADR_OSC, 8'h08);
        rd_chk("ctrl rst", ADR_CTRL, CTRL_RST);
        rd_chk("mod rst", ADR_MOD_BASE, MOD_RST);
        rd_chk("mask rst", ADR_IRQ_MASK, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_osc;
        logic [15:0] t0;
        bus_wr(ADR_OSC, 8'h10);
        t0 = mod_ticks;
        chk("int osc on", 1'b1, o_int_osc_en);
        chk("freq sel", 3'h1, o_int_freq_sel);
        rd_chk("osc settling", ADR_OSC, 8'h18);
        t0 = mod_ticks;
        repeat (8) @(posedge i_clk);
        #1;
        chk("periph ticks", 16'd8, mod_ticks - t0);
        rd_chk("osc stable", ADR_OSC, 8'h1c);
        bus_wr(ADR_OSC, 8'h00);
        chk("int osc off", 1'b0, o_int_osc_en);
        rd_chk("osc all clear", ADR_OSC, 8'h08);
        bus_wr(ADR_OSC, 8'h01);
        chk("int osc lf", 1'b1, o_int_osc_en);
        repeat (8) @(posedge i_clk);
        rd_chk("osc lf stable", ADR_OSC, 8'h0d);
        rd_chk("stat stable", ADR_IRQ_STAT, 8'h02);
        $display("test oscillator done");
    endtask

    task automatic t_idle;
        logic [15:0] c0;
        logic [15:0] m0;
        int n;
        bus_wr(ADR_CTRL, 8'h80);
        bus_wr(ADR_CTRL, 8'h83);
        chk("src int", 1'b1, o_clk_src_int);
        chk("pri osc off", 1'b0, o_pri_osc_en);
        rd_chk("osc ready clear", ADR_OSC, 8'h05);
        @(posedge i_clk);
        sleep_req <= 1'b1;
        @(posedge i_clk);
        sleep_req <= 1'b0;
        repeat (2) @(posedge i_clk);
        #1;
        c0 = cpu_ticks;
        m0 = mod_ticks;
        chk("cpu stopped", 1'b0, o_cpu_clk_en);
        chk("periph running", 1'b1, o_periph_clk_en);
        repeat (10) @(posedge i_clk);
        #1;
        chk("cpu ticks idle", c0, cpu_ticks);
        chk("periph ticks idle", 16'd10, mod_ticks - m0);
        @(posedge i_clk);
        i_wake_evt <= 1'b1;
        #1;
        m0 = mod_ticks;
        n = 0;
        while (o_cpu_clk_en !== 1'b1 && n < 50) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        chk("wake delay", P_SWITCH + 3, n);
        chk("periph ticks wake", n, mod_ticks - m0);
        chk("src after wake", 1'b1, o_clk_src_int);
        @(posedge i_clk);
        i_wake_evt <= 1'b0;
        rd_chk("ctrl after wake", ADR_CTRL, 8'h83);
        rd_chk("osc after wake", ADR_OSC, 8'h05);
        chk("irq masked", 1'b0, o_irq);
        bus_wr(ADR_IRQ_MASK, 8'h04);
        chk("irq raised", 1'b1, o_irq);
        rd_chk("stat wake", ADR_IRQ_STAT, 8'h05);
        chk("irq cleared", 1'b0, o_irq);
        $display("test idle done");
    endtask

    task automatic t_lposc;
        for (int k = 0; k < 4; k++) begin
            @(posedge i_clk);
            i_wdt_en <= k[0];
            i_fscm_en <= k[1];
            #1;
            chk("lposc run", k != 0, o_lposc_run);
        end
        $display("test low-power oscillator done");
    endtask

    task automatic t_modules;
        logic [15:0] m0;
        bus_wr(ADR_MOD_BASE + 8'h05, 8'h01);
        chk("func on", 1'b1, o_mod_func_en[5]);
        bus_wr(ADR_MOD_BASE + 8'h05, 8'h5a);
        chk("func off", 1'b0, o_mod_func_en[5]);
        chk("clk kept", 1'b1, o_mod_clk_en[5]);
        rd_chk("mod reg rw", ADR_MOD_BASE + 8'h05, 8'h5a);
        bus_wr(ADR_MOD_BASE + 8'h11, 8'h01);
        bus_wr(ADR_GATE_BASE + 8'h02, 8'h02);
        chk("gated clk", 1'b0, o_mod_clk_en[P_MOD]);
        chk("gated func", 1'b0, o_mod_func_en[P_MOD]);
        m0 = mod_ticks;
        repeat (5) @(posedge i_clk);
        #1;
        chk("gated ticks", m0, mod_ticks);
        rd_chk("gated read", ADR_MOD_BASE + 8'h11, 8'h00);
        bus_wr(ADR_MOD_BASE + 8'h11, 8'h00);
        bus_wr(ADR_GATE_BASE + 8'h02, 8'h00);
        rd_chk("gated write lost", ADR_MOD_BASE + 8'h11, 8'h01);
        for (int k = 0; k < N_GATE_REGS; k++) begin
            bus_wr(ADR_GATE_BASE + 8'(k), 8'h80);
            chk("gate bits", ~(32'h80 << (8 * k)), o_mod_clk_en);
            rd_chk("gate reg", ADR_GATE_BASE + 8'(k), 8'h80);
            bus_wr(ADR_GATE_BASE + 8'(k), 8'h00);
        end
        rd_chk("unmapped", 8'h30, 8'h00);
        $display("test modules done");
    endtask

    task automatic sleep_pulse;
        @(posedge i_clk);
        sleep_req <= 1'b1;
        @(posedge i_clk);
        sleep_req <= 1'b0;
        repeat (2) @(posedge i_clk);
        #1;
    endtask

    // Pin held until the CPU runs, then the synchroniser drains so no stale wake remains
    task automatic wake_pulse(output int n);
        @(posedge i_clk);
        i_wake_evt <= 1'b1;
        #1;
        n = 0;
        while (o_cpu_clk_en !== 1'b1 && n < 50) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        @(posedge i_clk);
        i_wake_evt <= 1'b0;
        repeat (3) @(posedge i_clk);
    endtask

    task automatic t_sleep;
        int n;
        bus_wr(ADR_CTRL, 8'h80);
        chk("pri osc back", 1'b1, o_pri_osc_en);
        repeat (P_PRI + 2) @(posedge i_clk);
        rd_chk("pri ready", ADR_OSC, 8'h0d);
        sleep_pulse;
        chk("pri idle cpu", 1'b0, o_cpu_clk_en);
        chk("pri idle periph", 1'b1, o_periph_clk_en);
        chk("pri idle osc", 1'b1, o_pri_osc_en);
        wake_pulse(n);
        chk("pri wake delay", P_SWITCH + 3, n);
        chk("pri src", 1'b0, o_clk_src_int);
        rd_chk("ctrl pri wake", ADR_CTRL, 8'h80);
        bus_wr(ADR_CTRL, 8'h00);
        sleep_pulse;
        chk("sleep cpu", 1'b0, o_cpu_clk_en);
        chk("sleep periph", 1'b0, o_periph_clk_en);
        chk("sleep mod clk", 32'h0, o_mod_clk_en);
        chk("sleep pri osc", 1'b0, o_pri_osc_en);
        wake_pulse(n);
        chk("sleep wake delay", P_SWITCH + 3, n);
        chk("sleep wake periph", 1'b1, o_periph_clk_en);
        $display("test sleep done");
    endtask

    task automatic summarize;
        $display("Counts: %0d checks, %0d mismatches", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Whole run is under two hundred cycles
    initial begin
        repeat (5000) @(posedge i_clk);
        n_errors++;
        summarize;
    end

    initial begin
        i_srst = 1'b1;
        i_bus = '0;
        sleep_req = 1'b0;
        i_wake_evt = 1'b0;
        i_wdt_en = 1'b0;
        i_fscm_en = 1'b0;
        n_errors = 0;
        checks = 0;
        repeat (5) @(posedge i_clk);
        i_srst <= 1'b0;
        t_reset;
        t_osc;
        t_idle;
        t_lposc;
        t_modules;
        t_sleep;
        summarize;
    end
endmodule
